// ---- logic/xpc_defines.vh ----
// Timing counts, field layout and reset values shared by the crosspoint controller.
`ifndef XPC_DEFINES_VH
`define XPC_DEFINES_VH
`define XPC_ADDR_W      6
`define XPC_ROW_LSB     3
`define XPC_COL_LSB     0
`define XPC_SETUP_NS    100
`define XPC_STROBE_NS   200
`define XPC_HOLD_NS     100
`define XPC_CLK_NS      100
`define XPC_SETUP_CYC   ((`XPC_SETUP_NS + `XPC_CLK_NS - 1) / `XPC_CLK_NS)
`define XPC_STROBE_CYC  ((`XPC_STROBE_NS + `XPC_CLK_NS - 1) / `XPC_CLK_NS)
`define XPC_HOLD_CYC    ((`XPC_HOLD_NS + `XPC_CLK_NS - 1) / `XPC_CLK_NS)
`define XPC_CNT_W       4
`define XPC_RST_CNT     {`XPC_CNT_W{1'h0}}
`define XPC_RST_ADDR    {`XPC_ADDR_W{1'h0}}
`define XPC_RST_DATA    1'h0
`define XPC_RST_STROBE  1'h0
`define XPC_RST_MRESET  1'h0
`define XPC_RST_DONE    1'h0
`endif

// ---- logic/xpc_controller.v ----
// Controller that drives the address, data, strobe and reset pins of the crosspoint latches.
// How it works
// (RULE1) The far device holds 64 write-only switch cells, so this side keeps no readback.
// (RULE2) Three row bits and three column bits on the pins select one of 64 cells.
// (RULE3) The far device enables a latch from its address match ANDed with the strobe.
// (RULE4) While strobe is high the addressed far cell follows the data pin.
// (RULE5) The far cell captures data on the strobe's falling edge and holds it.
// (RULE6) A stored 1 turns a switch on and a stored 0 turns it off.
// (RULE7) A write alters only the addressed cell.
// (RULE8) Any combination of cells may be on together.
// (RULE9) One data line feeds all 64 latches and only the enabled one takes it.
// (RULE10) A high master reset clears every far cell to 0 asynchronously.
// (RULE11) This controller holds master reset low while it sets up address and data.
// (RULE12) A write drives strobe high and then low after address and data are set up.
// (RULE13) Address is stable before strobe rises and steady while it is high.
// (RULE14) Data stays stable across the strobe's falling edge.
// (RULE15) With reset and strobe high together the clear wins in the far device.
// (RULE16) The far device shows its 64 cells as a switch-enable vector by row and column.
`timescale 1ns/1ps
`default_nettype none
`include "xpc_defines.vh"
module xpc_controller #(
	parameter SETUP_CYC  = `XPC_SETUP_CYC,
	parameter STROBE_CYC = `XPC_STROBE_CYC,
	parameter HOLD_CYC   = `XPC_HOLD_CYC
) (
	input  wire       clk,
	input  wire       rstn,
	input  wire       wr_valid,
	input  wire [2:0] wr_row,
	input  wire [2:0] wr_col,
	input  wire       wr_data,
	input  wire       clr_valid,
	output wire       req_ready,
	output wire       done,
	output wire [2:0] row_select_bits,
	output wire [2:0] column_select_bits,
	output wire       data_out,
	output wire       strobe_out,
	output wire       master_reset
);
	// Sequencer states: a write walks setup, strobe and hold, a clear is one reset pulse.
	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_SETUP  = 3'h1;
	localparam [2:0] ST_STROBE = 3'h2;
	localparam [2:0] ST_HOLD   = 3'h3;
	localparam [2:0] ST_CLEAR  = 3'h4;

	// A count outside 1 to CNT_MAX would wrap the phase counter, so it is pulled into range.
	localparam CNT_MAX    = (1 << `XPC_CNT_W) - 1;
	localparam SETUP_EFF  = (SETUP_CYC < 1) ? 1 :
		((SETUP_CYC > CNT_MAX) ? CNT_MAX : SETUP_CYC);
	localparam STROBE_EFF = (STROBE_CYC < 1) ? 1 :
		((STROBE_CYC > CNT_MAX) ? CNT_MAX : STROBE_CYC);
	localparam HOLD_EFF   = (HOLD_CYC < 1) ? 1 :
		((HOLD_CYC > CNT_MAX) ? CNT_MAX : HOLD_CYC);

	reg  [2:0]             state_ff;
	reg  [2:0]             nxt_state;
	reg  [`XPC_CNT_W-1:0]  cnt_ff;
	reg  [`XPC_CNT_W-1:0]  nxt_cnt;
	reg  [`XPC_ADDR_W-1:0] addr_ff;
	reg  [`XPC_ADDR_W-1:0] nxt_addr;
	reg                    data_ff;
	reg                    nxt_data;
	reg                    strobe_ff;
	reg                    nxt_strobe;
	reg                    reset_ff;
	reg                    nxt_reset;
	reg                    done_ff;
	reg                    nxt_done;
	wire                   cnt_zero;
	wire                   take_clr;
	wire                   take_wr;
	wire [`XPC_CNT_W-1:0]  cnt_one;
	wire [`XPC_CNT_W-1:0]  setup_load;
	wire [`XPC_CNT_W-1:0]  strobe_load;
	wire [`XPC_CNT_W-1:0]  hold_load;

	assign cnt_zero           = (cnt_ff == {`XPC_CNT_W{1'h0}});
	assign cnt_one            = {{(`XPC_CNT_W-1){1'h0}}, 1'h1};
	assign setup_load         = SETUP_EFF[`XPC_CNT_W-1:0] - cnt_one;
	assign strobe_load        = STROBE_EFF[`XPC_CNT_W-1:0] - cnt_one;
	assign hold_load          = HOLD_EFF[`XPC_CNT_W-1:0] - cnt_one;

	// A clear outranks a write presented in the same cycle.
	assign take_clr           = req_ready && clr_valid;
	assign take_wr            = req_ready && wr_valid && !clr_valid;
	assign req_ready          = (state_ff == ST_IDLE);
	assign done               = done_ff;
	assign row_select_bits    = addr_ff[`XPC_ROW_LSB +: 3]; // [RULE2]
	assign column_select_bits = addr_ff[`XPC_COL_LSB +: 3]; // [RULE2]
	assign data_out           = data_ff;
	assign strobe_out         = strobe_ff;
	assign master_reset       = reset_ff;

	always @* begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
		ST_IDLE: begin
			if (take_clr) begin
				nxt_state = ST_CLEAR;
				nxt_cnt   = strobe_load;
			end else if (take_wr) begin
				nxt_state = ST_SETUP;
				nxt_cnt   = setup_load;
			end
		end
		ST_SETUP: begin
			if (cnt_zero) begin
				nxt_state = ST_STROBE;
				nxt_cnt   = strobe_load;
			end else begin
				nxt_cnt = cnt_ff - cnt_one;
			end
		end
		ST_STROBE: begin
			if (cnt_zero) begin
				nxt_state = ST_HOLD;
				nxt_cnt   = hold_load;
			end else begin
				nxt_cnt = cnt_ff - cnt_one;
			end
		end
		ST_HOLD: begin
			if (cnt_zero) begin
				nxt_state = ST_IDLE;
			end else begin
				nxt_cnt = cnt_ff - cnt_one;
			end
		end
		ST_CLEAR: begin
			if (cnt_zero) begin
				nxt_state = ST_IDLE;
			end else begin
				nxt_cnt = cnt_ff - cnt_one;
			end
		end
		default: begin
			nxt_state = ST_IDLE;
			nxt_cnt   = `XPC_RST_CNT;
		end
		endcase
	end

	// Every flop resets to a quiet bus: strobe low, master reset low, nothing done.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= `XPC_RST_CNT;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Address and data latch at request time and stay put to the end of the hold phase.
	always @* begin
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		if (take_wr) begin
			nxt_addr = {wr_row, wr_col}; // [RULE13]
			nxt_data = wr_data; // [RULE14]
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_ff <= `XPC_RST_ADDR;
		end else begin
			addr_ff <= nxt_addr;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_ff <= `XPC_RST_DATA;
		end else begin
			data_ff <= nxt_data;
		end
	end

	always @* begin
		// Strobe rises only after setup and falls before hold, so address never moves under it.
		nxt_strobe = (nxt_state == ST_STROBE); // [RULE12] [RULE13]
		// Reset is kept low through every write phase so the far latches are never fighting it.
		nxt_reset  = (nxt_state == ST_CLEAR); // [RULE11] [RULE10]
		// Done marks the first idle cycle after a sequence, never a cycle spent waiting.
		nxt_done   = (nxt_state == ST_IDLE) && !req_ready;
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strobe_ff <= `XPC_RST_STROBE;
		end else begin
			strobe_ff <= nxt_strobe;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reset_ff <= `XPC_RST_MRESET;
		end else begin
			reset_ff <= nxt_reset;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done_ff <= `XPC_RST_DONE;
		end else begin
			done_ff <= nxt_done;
		end
	end
endmodule
`default_nettype wire

// ---- bench/xpc_dev.sv ----
// Behavioural model of the 64 crosspoint latches.
`timescale 1ns/1ps
`default_nettype none
module xpc_dev (
	input	wire logic [2:0]	ra,
	input	wire logic [2:0]	ca,
	input	wire logic		d,
	input	wire logic		s,
	input	wire logic		mr,
	output	var logic [63:0]	sw
);
	// Clear wins over strobe, as a real part would not let a write slip past a reset.
	always @* begin
		if (mr)
			sw = '0;
		else if (s)
			sw[{ra, ca}] = d;
	end
endmodule
`default_nettype wire

// ---- bench/xpc_pin_asserts.sv ----
// Pin protocol checks on the controller.
`timescale 1ns/1ps
`default_nettype none
module xpc_pin_asserts (
	input	wire logic		clk,
	input	wire logic		rstn,
	input	wire logic		wr_valid,
	input	wire logic		clr_valid,
	input	wire logic		req_ready,
	input	wire logic [2:0]	row_select_bits,
	input	wire logic [2:0]	column_select_bits,
	input	wire logic		data_out,
	input	wire logic		strobe_out,
	input	wire logic		master_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire logic [5:0] a = {row_select_bits, column_select_bits};
	reset_low_a: assert property (strobe_out || $changed(a) |-> !master_reset)
		else $error("reset high during a write");
	strobe_pulse_a: assert property (wr_valid && req_ready && !clr_valid |=>
		!strobe_out ##1 strobe_out [*2] ##1 !strobe_out) else $error("bad strobe pulse");
	addr_steady_a: assert property (strobe_out |-> $stable(a))
		else $error("address moved under strobe");
	data_hold_a: assert property ($fell(strobe_out) |-> $stable(data_out))
		else $error("data moved at strobe fall");
	wr_c: cover property (wr_valid && req_ready && !clr_valid);
	clr_c: cover property ($rose(master_reset));
	b2b_c: cover property ($fell(strobe_out) ##3 $rose(strobe_out));
endmodule
bind xpc_controller xpc_pin_asserts u_chk (.clk, .rstn, .wr_valid, .clr_valid, .req_ready,
	.row_select_bits, .column_select_bits, .data_out, .strobe_out, .master_reset);
`default_nettype wire

// ---- bench/xpc_controller_test.sv ----
// Self-checking bench for the crosspoint controller.
`timescale 1ns/1ps
`default_nettype none
`include "xpc_defines.vh"
module xpc_controller_test;
	logic clk = 1'b0, rstn = 1'b0, wr_valid = 1'b0, clr_valid = 1'b0, wr_data = 1'b0;
	logic [2:0] wr_row = 3'h0, wr_col = 3'h0;
	wire logic req_ready, done, data_out, strobe_out, master_reset;
	wire logic [2:0] row_select_bits, column_select_bits;
	wire logic [63:0] sw;
	logic [63:0] exp_sw = '0;
	integer err_total = 0, total_checks = 0, seed = 12841, i, n, exp_n;
	always #50 clk = ~clk;
	xpc_controller u_dut (.clk, .rstn, .wr_valid, .wr_row, .wr_col, .wr_data, .clr_valid,
		.req_ready, .done, .row_select_bits, .column_select_bits, .data_out, .strobe_out,
		.master_reset);
	xpc_dev u_dev (.ra(row_select_bits), .ca(column_select_bits), .d(data_out),
		.s(strobe_out), .mr(master_reset), .sw(sw));
	task give_verdict;
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input string what, input logic [63:0] seen, input logic [63:0] want);
		total_checks = total_checks + 1;
		if (seen !== want) begin
			err_total = err_total + 1;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask
	// Called just after a rising edge; the next request may follow at once.
	task send(input logic clr, input logic [5:0] a, input logic d);
		{clr_valid, wr_valid, wr_row, wr_col, wr_data} = {clr, 1'b1, a, d};
		@(posedge clk);
		#1;
		{clr_valid, wr_valid} = 2'h0;
		for (n = 0; n < 20 && done !== 1'b1; n = n + 1) begin
			@(posedge clk);
			#1;
		end
		if (clr)
			exp_sw = '0;
		else
			exp_sw[a] = d;
		exp_n = clr ? `XPC_STROBE_CYC : `XPC_SETUP_CYC + `XPC_STROBE_CYC + `XPC_HOLD_CYC;
		check("done delay", 64'(n), 64'(exp_n));
		check("switches", sw, exp_sw);
	endtask
	initial begin
		#500000;
		err_total = err_total + 1;
		give_verdict;
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		check("idle pins", 64'({req_ready, strobe_out, master_reset}), 64'h4);
		// The far latches power up unknown, so the run opens with a clear.
		send(1'b1, 6'h00, 1'b0);
		for (i = 0; i < 64; i = i + 1)
			send(1'b0, 6'(i), 1'b1);
		send(1'b1, 6'h3f, 1'b0);
		for (i = 0; i < 60; i = i + 1)
			send(i % 17 == 16, 6'($random(seed)), 1'($random(seed)));
		give_verdict;
	end
endmodule
`default_nettype wire
